// ===== inc/dbhd_pkg.sv
package dbhd_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] DBHD_OFS_MASK0 = 8'h00;
	localparam logic [7:0] DBHD_OFS_MASK1 = 8'h04;
	localparam logic [7:0] DBHD_OFS_STATUS = 8'h10;
	localparam logic [7:0] DBHD_OFS_CLEAR = 8'h14;
	localparam logic [7:0] DBHD_OFS_ENABLE = 8'h18;
	// ------------------------------------------------------------
	// mask register fields
	// ------------------------------------------------------------
	localparam int DBHD_ADDRMSK_HI = 31;
	localparam int DBHD_ADDRMSK_LO = 18;
	localparam int DBHD_ADDRMSK_W = DBHD_ADDRMSK_HI - DBHD_ADDRMSK_LO + 1;
	localparam int DBHD_WP_BIT = 8;
	localparam int DBHD_TYPEMSK_HI = 6;
	localparam int DBHD_TYPEMSK_LO = 1;
	localparam int DBHD_VALID_BIT = 0;
	localparam logic [31:0] DBHD_MASK_WMASK = 32'hFFFC017F;
	localparam logic [31:0] DBHD_MASK_RESET = 32'h00000000;
	// access type positions within the six-bit type field
	localparam int DBHD_TY_USR_DATA = 0;
	localparam int DBHD_TY_USR_CODE = 1;
	localparam int DBHD_TY_SUP_DATA = 2;
	localparam int DBHD_TY_SUP_CODE = 3;
	localparam int DBHD_TY_ALT = 4;
	localparam int DBHD_TY_CPU = 5;
	// ------------------------------------------------------------
	// event status bits
	// ------------------------------------------------------------
	localparam int DBHD_EV_W = 2;
	localparam int DBHD_EV_ADDR_EXC = 0;
	localparam int DBHD_EV_ACC_EXC = 1;
	localparam logic [DBHD_EV_W-1:0] DBHD_EV_RESET = 2'h0;

	typedef enum logic [1:0] {
		DBHD_FWD_IDLE,
		DBHD_FWD_CS_WAIT,
		DBHD_FWD_EXT_WAIT
	} dbhd_fwd_state_t;
endpackage : dbhd_pkg

// ===== hw/dbhd_hit_eval.sv
`timescale 1ns/1ps
`default_nettype none
module dbhd_hit_eval (
	// block configuration
	input wire logic [31:0] mask_reg,
	input wire logic [13:0] base_addr,
	// current cycle
	input wire logic [31:0] cyc_addr,
	input wire logic [5:0] cyc_type,
	input wire logic cyc_write,
	// outcome
	output logic hit,
	output logic wp_write
);
	wire [13:0] base_addr_mask;
	wire [13:0] addr_miss;
	wire [5:0] access_type_masks;
	wire addr_match;
	wire type_ok;
	wire valid;
	wire wp;

	assign base_addr_mask = mask_reg[dbhd_pkg::DBHD_ADDRMSK_HI:
		dbhd_pkg::DBHD_ADDRMSK_LO];
	assign access_type_masks = mask_reg[dbhd_pkg::DBHD_TYPEMSK_HI:
		dbhd_pkg::DBHD_TYPEMSK_LO];
	assign valid = mask_reg[dbhd_pkg::DBHD_VALID_BIT];
	assign wp = mask_reg[dbhd_pkg::DBHD_WP_BIT];
	// per-bit compare, mask one drops the bit
	assign addr_miss = (cyc_addr[dbhd_pkg::DBHD_ADDRMSK_HI:
		dbhd_pkg::DBHD_ADDRMSK_LO] ^ base_addr) & ~base_addr_mask;
	assign addr_match = (addr_miss == 14'h0);
	assign type_ok = ((access_type_masks & cyc_type) == 6'h00);
	assign hit = valid & addr_match & type_ok;
	assign wp_write = hit & cyc_write & wp;
endmodule : dbhd_hit_eval
`default_nettype wire

// ===== hw/dbhd_top.sv
`timescale 1ns/1ps
`default_nettype none
module dbhd_top #(
	parameter int NUM_BLOCKS = 2
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// base address of each block from the address-and-control registers
	input wire logic [13:0] dram_block_addr_ctrl0,
	input wire logic [13:0] dram_block_addr_ctrl1,
	// internal bus cycle
	input wire logic cyc_valid,
	input wire logic [31:0] cyc_addr,
	input wire logic cyc_write,
	input wire logic cyc_cpu_space,
	input wire logic cyc_alt_master,
	input wire logic cyc_supervisor,
	input wire logic cyc_code,
	// dram timing engine side
	output logic [1:0] dram_hit,
	output logic dram_write_ok,
	// chip-select and external bus side
	output logic cs_fwd,
	input wire logic cs_done,
	input wire logic cs_hit,
	output logic ext_cycle_req,
	input wire logic ext_done,
	input wire logic ext_ack,
	// exceptions and interrupt
	output logic addr_exc,
	output logic acc_exc,
	output logic irq
);
	// ------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------
	if (NUM_BLOCKS != 2) begin : g_bad_blocks
		$error("dbhd_top: only two dram blocks are served");
	end

	// ------------------------------------------------------------
	// cycle classification
	// ------------------------------------------------------------
	function automatic logic [5:0] dbhd_classify(input logic cpu_sp,
		input logic alt, input logic sup, input logic code);
		logic [5:0] t;
		t = 6'h00;
		if (cpu_sp)
			t[dbhd_pkg::DBHD_TY_CPU] = 1'b1;
		else if (alt)
			t[dbhd_pkg::DBHD_TY_ALT] = 1'b1;
		else if (sup && code)
			t[dbhd_pkg::DBHD_TY_SUP_CODE] = 1'b1;
		else if (sup)
			t[dbhd_pkg::DBHD_TY_SUP_DATA] = 1'b1;
		else if (code)
			t[dbhd_pkg::DBHD_TY_USR_CODE] = 1'b1;
		else
			t[dbhd_pkg::DBHD_TY_USR_DATA] = 1'b1;
		return t;
	endfunction : dbhd_classify

	// cpu space wins over alternate master so interrupt acknowledge
	// is never mistaken for a dma cycle
	wire [5:0] cyc_type;
	assign cyc_type = dbhd_classify(cyc_cpu_space, cyc_alt_master,
		cyc_supervisor, cyc_code);

	// ------------------------------------------------------------
	// ahb-lite address phase capture
	// ------------------------------------------------------------
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	wire addr_phase;
	wire rd_take;
	wire wr_take;

	assign addr_phase = hsel & htrans[1] & hready;
	assign rd_take = addr_phase & ~hwrite;
	assign wr_take = addr_phase & hwrite;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else begin
			wr_pend_r <= wr_take;
			wr_addr_r <= haddr[7:0];
		end
	end

	// ------------------------------------------------------------
	// register offset decode, shared by the write and read paths
	// ------------------------------------------------------------
	// one-hot: 0 mask0, 1 mask1, 2 status, 3 clear, 4 enable
	function automatic logic [4:0] dbhd_reg_decode(input logic [7:0] ofs);
		logic [4:0] s;
		s = 5'h00;
		s[0] = (ofs == dbhd_pkg::DBHD_OFS_MASK0);
		s[1] = (ofs == dbhd_pkg::DBHD_OFS_MASK1);
		s[2] = (ofs == dbhd_pkg::DBHD_OFS_STATUS);
		s[3] = (ofs == dbhd_pkg::DBHD_OFS_CLEAR);
		s[4] = (ofs == dbhd_pkg::DBHD_OFS_ENABLE);
		return s;
	endfunction : dbhd_reg_decode

	wire [4:0] wr_sel;
	wire [4:0] rd_sel;
	wire wr_mask0;
	wire wr_mask1;
	wire wr_clear;
	wire wr_enable;
	// only the low byte is decoded, so the map repeats every 256 bytes
	assign wr_sel = dbhd_reg_decode(wr_addr_r);
	assign rd_sel = dbhd_reg_decode(haddr[7:0]);
	assign wr_mask0 = wr_pend_r & wr_sel[0];
	assign wr_mask1 = wr_pend_r & wr_sel[1];
	assign wr_clear = wr_pend_r & wr_sel[3];
	assign wr_enable = wr_pend_r & wr_sel[4];

	// ------------------------------------------------------------
	// mask registers
	// ------------------------------------------------------------
	logic [31:0] mask0_r;
	logic [31:0] mask1_r;
	wire [31:0] mask0_nxt;
	wire [31:0] mask1_nxt;
	// reserved bits never stored, so they read back as zero
	assign mask0_nxt = wr_mask0 ? (hwdata & dbhd_pkg::DBHD_MASK_WMASK)
		: mask0_r;
	assign mask1_nxt = wr_mask1 ? (hwdata & dbhd_pkg::DBHD_MASK_WMASK)
		: mask1_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask0_r <= dbhd_pkg::DBHD_MASK_RESET;
			mask1_r <= dbhd_pkg::DBHD_MASK_RESET;
		end else begin
			mask0_r <= mask0_nxt;
			mask1_r <= mask1_nxt;
		end
	end

	// ------------------------------------------------------------
	// per-block hit evaluation
	// ------------------------------------------------------------
	wire [31:0] mask_arr [2];
	wire [13:0] base_arr [2];
	wire [1:0] blk_hit;
	wire [1:0] blk_wp;
	assign mask_arr[0] = mask0_r;
	assign mask_arr[1] = mask1_r;
	assign base_arr[0] = dram_block_addr_ctrl0;
	assign base_arr[1] = dram_block_addr_ctrl1;

	for (genvar i = 0; i < 2; i++) begin : g_blk
		dbhd_hit_eval u_eval (
			.mask_reg(mask_arr[i]),
			.base_addr(base_arr[i]),
			.cyc_addr(cyc_addr),
			.cyc_type(cyc_type),
			.cyc_write(cyc_write),
			.hit(blk_hit[i]),
			.wp_write(blk_wp[i])
		);
	end

	wire any_wp;
	wire [1:0] hit_nxt;
	assign any_wp = cyc_valid & (|blk_wp);
	// a protected write never reaches the dram engine
	assign hit_nxt = (cyc_valid & ~any_wp) ? blk_hit : 2'h0;

	// ------------------------------------------------------------
	// protected write forwarding
	// ------------------------------------------------------------
	dbhd_pkg::dbhd_fwd_state_t fwd_r;
	dbhd_pkg::dbhd_fwd_state_t fwd_nxt;
	wire fwd_start;
	wire ext_start;
	wire ext_fail;
	// one forward at a time; a new protected write while busy is not
	// forwarded, it only raises the address exception and the write is dropped
	assign fwd_start = any_wp & (fwd_r == dbhd_pkg::DBHD_FWD_IDLE);
	assign ext_start = (fwd_r == dbhd_pkg::DBHD_FWD_CS_WAIT) & cs_done
		& ~cs_hit;
	assign ext_fail = (fwd_r == dbhd_pkg::DBHD_FWD_EXT_WAIT) & ext_done
		& ~ext_ack;

	always_comb begin
		fwd_nxt = fwd_r;
		case (fwd_r)
			dbhd_pkg::DBHD_FWD_IDLE: begin
				if (fwd_start)
					fwd_nxt = dbhd_pkg::DBHD_FWD_CS_WAIT;
			end
			dbhd_pkg::DBHD_FWD_CS_WAIT: begin
				if (cs_done)
					fwd_nxt = cs_hit ? dbhd_pkg::DBHD_FWD_IDLE
						: dbhd_pkg::DBHD_FWD_EXT_WAIT;
			end
			dbhd_pkg::DBHD_FWD_EXT_WAIT: begin
				if (ext_done)
					fwd_nxt = dbhd_pkg::DBHD_FWD_IDLE;
			end
			default: fwd_nxt = dbhd_pkg::DBHD_FWD_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// event status, enable and interrupt
	// ------------------------------------------------------------
	logic [1:0] sts_r;
	logic [1:0] en_r;
	wire [1:0] ev_set;
	wire [1:0] sts_nxt;
	wire [1:0] en_nxt;
	assign ev_set[dbhd_pkg::DBHD_EV_ADDR_EXC] = any_wp;
	assign ev_set[dbhd_pkg::DBHD_EV_ACC_EXC] = ext_fail;
	// set wins over a clear in the same cycle
	assign sts_nxt = (sts_r & ~(wr_clear ? hwdata[1:0] : 2'h0)) | ev_set;
	assign en_nxt = wr_enable ? hwdata[1:0] : en_r;

	// ------------------------------------------------------------
	// read data mux, looks at next values so a read right after a
	// write returns the new contents
	// ------------------------------------------------------------
	wire [31:0] rd_data;
	assign rd_data =
		rd_sel[0] ? mask0_nxt :
		rd_sel[1] ? mask1_nxt :
		rd_sel[2] ? {30'h0, sts_nxt} :
		rd_sel[4] ? {30'h0, en_nxt} :
		32'h00000000;

	// ------------------------------------------------------------
	// forward state, status and enable
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fwd_r <= dbhd_pkg::DBHD_FWD_IDLE;
			sts_r <= dbhd_pkg::DBHD_EV_RESET;
			en_r <= dbhd_pkg::DBHD_EV_RESET;
		end else begin
			fwd_r <= fwd_nxt;
			sts_r <= sts_nxt;
			en_r <= en_nxt;
		end
	end

	// ------------------------------------------------------------
	// output registers
	// ------------------------------------------------------------
	// bus answer: zero wait and always okay, the master never stalls
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hrdata <= rd_take ? rd_data : hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// decode outcome, one-cycle pulses towards the dram engine
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dram_hit <= 2'h0;
			dram_write_ok <= 1'b0;
		end else begin
			dram_hit <= hit_nxt;
			dram_write_ok <= cyc_write & (|hit_nxt);
		end
	end

	// requests towards the chip-select and external bus side
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cs_fwd <= 1'b0;
			ext_cycle_req <= 1'b0;
		end else begin
			cs_fwd <= fwd_start;
			ext_cycle_req <= ext_start;
		end
	end

	// irq built from next values so it moves with the status bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_exc <= 1'b0;
			acc_exc <= 1'b0;
			irq <= 1'b0;
		end else begin
			addr_exc <= any_wp;
			acc_exc <= ext_fail;
			irq <= |(sts_nxt & en_nxt);
		end
	end
endmodule : dbhd_top
`default_nettype wire

// ===== testbench/dbhd_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dbhd_monitor (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// watched ports
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic cyc_valid,
	input wire logic cyc_write,
	input wire logic [1:0] dram_hit,
	input wire logic dram_write_ok,
	input wire logic cs_fwd,
	input wire logic cs_done,
	input wire logic cs_hit,
	input wire logic ext_cycle_req,
	input wire logic ext_done,
	input wire logic ext_ack,
	input wire logic addr_exc,
	input wire logic acc_exc
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	sequence s_wr_fwd;
		cyc_valid && cyc_write ##1 cs_fwd;
	endsequence
	AST_FWD_EXC: assert property (s_wr_fwd |-> addr_exc)
		else $error("forward without address exception");
	AST_EXC_CAUSE: assert property (addr_exc |-> $past(cyc_valid && cyc_write))
		else $error("address exception without a write");
	AST_WOK_HIT: assert property (dram_write_ok |->
		dram_hit != 2'h0 && $past(cyc_write))
		else $error("write allowed without hit");
	AST_HIT_CAUSE: assert property (dram_hit != 2'h0 |-> $past(cyc_valid))
		else $error("hit without a cycle");
	AST_HIT_PULSE: assert property (dram_hit[0] && !cyc_valid |=> !dram_hit[0])
		else $error("hit longer than one cycle");
	AST_EXT_CAUSE: assert property (ext_cycle_req |-> $past(cs_done && !cs_hit))
		else $error("external cycle without chip-select miss");
	AST_ACC_CAUSE: assert property (acc_exc |-> $past(ext_done && !ext_ack))
		else $error("access exception without missing ack");
	AST_BUS_OKAY: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
endmodule : dbhd_monitor
bind dbhd_top dbhd_monitor u_mon (.hclk(hclk), .hresetn(hresetn),
	.hreadyout(hreadyout), .hresp(hresp), .cyc_valid(cyc_valid),
	.cyc_write(cyc_write), .dram_hit(dram_hit), .dram_write_ok(dram_write_ok),
	.cs_fwd(cs_fwd), .cs_done(cs_done), .cs_hit(cs_hit),
	.ext_cycle_req(ext_cycle_req), .ext_done(ext_done), .ext_ack(ext_ack),
	.addr_exc(addr_exc), .acc_exc(acc_exc));
`default_nettype wire

// ===== testbench/dbhd_cs_model.sv
`timescale 1ns/1ps
`default_nettype none
module dbhd_cs_model (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// requests and scenario knobs
	input wire logic cs_fwd,
	input wire logic ext_cycle_req,
	input wire logic hit_cfg,
	input wire logic ack_cfg,
	input wire logic [3:0] delay,
	// answers
	output logic cs_done,
	output logic cs_hit,
	output logic ext_done,
	output logic ext_ack
);
	int cs_cnt;
	int ex_cnt;
	// hit and ack lines toggle outside the done pulse so stale values never pass
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cs_cnt <= -1;
			ex_cnt <= -1;
			cs_done <= 1'b0;
			cs_hit <= 1'b0;
			ext_done <= 1'b0;
			ext_ack <= 1'b0;
		end else begin
			cs_done <= cs_cnt == 0;
			cs_hit <= (cs_cnt == 0) ? hit_cfg : ~cs_hit;
			ext_done <= ex_cnt == 0;
			ext_ack <= (ex_cnt == 0) ? ack_cfg : ~ext_ack;
			cs_cnt <= cs_fwd ? int'(delay) : cs_cnt - int'(cs_cnt >= 0);
			ex_cnt <= ext_cycle_req ? int'(delay) : ex_cnt - int'(ex_cnt >= 0);
		end
	end
endmodule : dbhd_cs_model
`default_nettype wire

// ===== testbench/dbhd_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module dbhd_top_test;
	localparam logic [31:0] M0 = 32'(dbhd_pkg::DBHD_OFS_MASK0);
	localparam logic [31:0] M1 = 32'(dbhd_pkg::DBHD_OFS_MASK1);
	localparam logic [31:0] ST = 32'(dbhd_pkg::DBHD_OFS_STATUS);
	localparam logic [31:0] CL = 32'(dbhd_pkg::DBHD_OFS_CLEAR);
	localparam logic [31:0] EN = 32'(dbhd_pkg::DBHD_OFS_ENABLE);
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, cyc_valid, cyc_write;
	logic c_cpu, c_alt, c_sup, c_code, dram_write_ok, cs_fwd, cs_done, cs_hit;
	logic ext_cycle_req, ext_done, ext_ack, addr_exc, acc_exc, irq, hit_cfg;
	logic ack_cfg;
	logic [1:0] htrans, dram_hit;
	logic [31:0] haddr, hwdata, hrdata, cyc_addr, rd;
	logic [13:0] base0, base1;
	logic [3:0] dly;
	logic [31:0] ofs [5] = '{M0, M1, ST, EN, 32'h20};
	int mismatches, samples_checked, n_ext, n_acc;
	dbhd_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.dram_block_addr_ctrl0(base0), .dram_block_addr_ctrl1(base1),
		.cyc_valid(cyc_valid), .cyc_addr(cyc_addr), .cyc_write(cyc_write),
		.cyc_cpu_space(c_cpu), .cyc_alt_master(c_alt), .cyc_supervisor(c_sup),
		.cyc_code(c_code), .dram_hit(dram_hit), .dram_write_ok(dram_write_ok),
		.cs_fwd(cs_fwd), .cs_done(cs_done), .cs_hit(cs_hit),
		.ext_cycle_req(ext_cycle_req), .ext_done(ext_done), .ext_ack(ext_ack),
		.addr_exc(addr_exc), .acc_exc(acc_exc), .irq(irq));
	dbhd_cs_model far (.hclk(hclk), .hresetn(hresetn), .cs_fwd(cs_fwd),
		.ext_cycle_req(ext_cycle_req), .hit_cfg(hit_cfg), .ack_cfg(ack_cfg),
		.delay(dly), .cs_done(cs_done), .cs_hit(cs_hit), .ext_done(ext_done),
		.ext_ack(ext_ack));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic report_and_stop();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string what, input logic [31:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic edge_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			mismatches++;
			report_and_stop();
		end
	endtask : edge_ready
	task automatic ahb(input logic w, input logic [31:0] a, d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		edge_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		edge_ready();
		rd = hrdata;
	endtask : ahb
	// ty: 0 user data .. 3 supervisor code, 4 alt master, 5 cpu space
	task automatic cyc(input logic [31:0] a, input logic w, input int ty,
			input logic [31:0] exp);
		cyc_valid <= 1'b1;
		cyc_addr <= a;
		cyc_write <= w;
		c_cpu <= ty == 5;
		c_alt <= ty == 4;
		c_sup <= ty == 2 || ty == 3;
		c_code <= ty == 1 || ty == 3;
		@(posedge hclk);
		cyc_valid <= 1'b0;
		#1;
		chk("decode", exp, {dram_hit, dram_write_ok, cs_fwd, addr_exc});
		@(posedge hclk);
	endtask : cyc
	always @(posedge hclk) begin
		if (!hresetn) begin
			n_ext <= 0;
			n_acc <= 0;
		end else begin
			n_ext <= n_ext + int'(ext_cycle_req === 1'b1);
			n_acc <= n_acc + int'(acc_exc === 1'b1);
		end
	end
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	initial begin
		{hresetn, hsel, hwrite, cyc_valid, cyc_write, c_cpu, c_alt} = '0;
		{c_sup, c_code, hit_cfg, ack_cfg, htrans, haddr, hwdata} = '0;
		{cyc_addr, mismatches, samples_checked} = '0;
		base0 = 14'h0123;
		base1 = 14'h2A5C;
		dly = 4'h3;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (ofs[i]) begin
			ahb(1'b0, ofs[i], 32'h0);
			chk("reset value", 32'h0, rd);
		end
		ahb(1'b1, M1, 32'hFFFFFFFF);
		ahb(1'b0, M1, 32'h0);
		chk("mask1 readback", 32'hFFFC017F, rd);
		ahb(1'b1, M1, 32'h0);
		cyc({base0, 18'h0}, 1'b0, 0, 32'h0);
		$display("registers done");
		ahb(1'b1, M0, 32'h00140001);
		cyc({base0, 18'h3}, 1'b1, 0, 32'hC);
		cyc({base0 ^ 14'h0005, 18'h0}, 1'b0, 0, 32'h8);
		cyc({base0 ^ 14'h0002, 18'h0}, 1'b0, 0, 32'h0);
		ahb(1'b1, M1, 32'h1);
		cyc({base1, 18'h0}, 1'b0, 0, 32'h10);
		for (int i = 0; i < 6; i++) begin
			ahb(1'b1, M0, 32'h1 | (32'h2 << i));
			cyc({base0, 18'h0}, 1'b0, i, 32'h0);
			ahb(1'b1, M0, 32'h1);
			cyc({base0, 18'h0}, 1'b0, i, 32'h8);
		end
		$display("decode done");
		ahb(1'b1, EN, 32'h2);
		ahb(1'b1, M0, 32'h101);
		cyc({base0, 18'h0}, 1'b0, 0, 32'h8);
		hit_cfg <= 1'b1;
		cyc({base0, 18'h0}, 1'b1, 0, 32'h3);
		repeat (16) @(posedge hclk);
		chk("ext cycles", 32'h0, n_ext);
		chk("irq masked", 32'h0, irq);
		hit_cfg <= 1'b0;
		ack_cfg <= 1'b1;
		cyc({base0, 18'h0}, 1'b1, 0, 32'h3);
		repeat (16) @(posedge hclk);
		chk("ext cycles", 32'h1, n_ext);
		chk("acc exc", 32'h0, n_acc);
		ack_cfg <= 1'b0;
		cyc({base0, 18'h0}, 1'b1, 0, 32'h3);
		repeat (16) @(posedge hclk);
		chk("acc exc", 32'h1, n_acc);
		chk("irq", 32'h1, irq);
		ahb(1'b0, ST, 32'h0);
		chk("status", 32'h3, rd);
		ahb(1'b1, CL, 32'h3);
		ahb(1'b0, ST, 32'h0);
		chk("status clear", 32'h0, rd);
		chk("irq clear", 32'h0, irq);
		$display("protect done");
		report_and_stop();
	end
endmodule : dbhd_top_test
`default_nettype wire
